// File: rtl/mss_pkg.sv
// Constants, field layouts and types shared by the motor start-up sequencer.
// Assumes a single 10 MHz core clock; the tick and probe gap times are converted to cycles here, align and brake stay in ms.
package mss_pkg;

  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned TICK_MS         = 1;
  localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned PROBE_GAP_US    = 100;
  localparam int unsigned PROBE_GAP_CYC   = (PROBE_GAP_US * (CLK_HZ / 1_000_000));
  localparam logic [15:0] PROBE_MAX_CYC   = 16'hffff;

  // Register byte offsets
  localparam logic [7:0] ADDR_CFG0   = 8'h00;
  localparam logic [7:0] ADDR_CFG1   = 8'h04;
  localparam logic [7:0] ADDR_CFG2   = 8'h08;
  localparam logic [7:0] ADDR_CTRL   = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // CFG0 fields
  localparam int BRK_HOLD_LSB  = 0;
  localparam int BRK_CUR_LSB   = 4;
  localparam int REV_LIM_LSB   = 8;
  localparam int ALIGN_LSB     = 16;
  localparam int OL_CUR_LSB    = 20;
  // CFG1 fields
  localparam int PRB_THR_LSB   = 0;
  localparam int PRB_REL_BIT   = 4;
  localparam int PRB_GAP_LSB   = 8;
  localparam int INIT_ANG_LSB  = 12;
  // CFG2 fields
  localparam int HANDOFF_LSB   = 0;
  localparam int ACC_LIN_LSB   = 8;
  localparam int ACC_QUAD_LSB  = 12;
  // CTRL fields
  localparam int RUN_BIT       = 0;
  localparam int REVDRV_EN_BIT = 1;
  // STATUS fields
  localparam int ST_STATE_LSB  = 0;
  localparam int ST_POS_LSB    = 4;
  localparam int ST_CLOSED_BIT = 8;

  localparam logic [31:0] CFG0_RST = 32'h0000_0000;
  localparam logic [31:0] CFG1_RST = 32'h0000_0000;
  localparam logic [31:0] CFG2_RST = 32'h0000_0000;
  localparam logic [1:0]  CTRL_RST = 2'h0;

  // Base values of the coded fields; align and brake times in ms, speed limit and ramp steps unscaled
  localparam logic [12:0] ALIGN_BASE_MS = 13'h0028;
  localparam logic [12:0] BRAKE_UNIT_MS = 13'h000a;
  localparam logic [7:0]  REV_LIM_BASE  = 8'h08;
  localparam logic [23:0] ACC_LIN_BASE  = 24'h000100;
  localparam logic [23:0] ACC_QUAD_BASE = 24'h000008;

  localparam logic [2:0] SECTORS      = 3'h6;
  localparam logic [2:0] ALIGN_SECTOR = 3'h0;

  typedef struct packed {
    logic [2:0] brake_hold_time;
    logic [1:0] brake_exit_current;
    logic [1:0] reverse_speed_limit;
    logic [2:0] align_duration;
    logic [1:0] open_loop_current;
    logic [3:0] probe_current_threshold;
    logic       probe_release_select;
    logic [1:0] probe_pulse_interval;
    logic [1:0] initial_drive_angle;
    logic [4:0] closed_loop_handoff_speed;
    logic [2:0] accel_linear_coef;
    logic [2:0] accel_quadratic_coef;
    logic       reverse_drive_en;
  } mss_cfg_t;

  typedef struct packed {
    logic [2:0] hs;
    logic [2:0] ls;
  } mss_gate_t;

  // Gray-coded along idle, coast, brake, probe, gap, align, accel, closed
  typedef enum logic [3:0] {
    MSS_IDLE   = 4'h0,
    MSS_COAST  = 4'h1,
    MSS_BRAKE  = 4'h3,
    MSS_PROBE  = 4'h2,
    MSS_GAP    = 4'h6,
    MSS_ALIGN  = 4'h7,
    MSS_ACCEL  = 4'h5,
    MSS_CLOSED = 4'h4,
    MSS_REVDRV = 4'hc
  } mss_state_t;

endpackage : mss_pkg

// File: rtl/mss_sequencer.sv
// Start-up sequencer of a three-phase sensorless motor driver with a Wishbone register port.
// Assumes speed-sense results arrive from same-clock logic and current comparators from pins.
//
// Local design decisions: the register addresses and the Wishbone register port.
`timescale 1ns/10ps

module mss_sequencer #(
  parameter int unsigned TICK_CYCLES = mss_pkg::TICK_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        dir_i,
  input  wire logic        cur_probe_i,
  input  wire logic        cur_brake_low_i,
  input  wire logic        speed_valid_i,
  input  wire logic        speed_reverse_i,
  input  wire logic [7:0]  speed_value_i,
  output logic      [2:0]  hs_on_o,
  output logic      [2:0]  ls_on_o,
  output logic      [1:0]  drive_level_o,
  output logic      [3:0]  probe_threshold_o,
  output logic      [1:0]  brake_threshold_o,
  output logic      [2:0]  handoff_sector_o,
  output logic             closed_loop_o
);

  mss_pkg::mss_state_t state_ff;
  mss_pkg::mss_state_t nxt_state;
  mss_pkg::mss_cfg_t   cfg_ff;
  mss_pkg::mss_gate_t  nxt_gate;

  logic [31:0] cfg0_ff;
  logic [31:0] cfg1_ff;
  logic [31:0] cfg2_ff;
  logic [1:0]  ctrl_ff;
  logic        ack_ff;
  logic [31:0] rdata_ff;

  logic [2:0]  dir_sync_ff;
  logic [1:0]  prb_sync_ff;
  logic [1:0]  brk_sync_ff;

  logic [13:0] tick_cnt_ff;
  logic        tick_ff;
  logic [12:0] ms_cnt_ff;
  logic [15:0] cyc_cnt_ff;
  logic [2:0]  probe_idx_ff;
  logic [15:0] best_time_ff;
  logic [2:0]  best_idx_ff;
  logic [2:0]  sector_ff;
  logic [23:0] speed_ff;
  logic [23:0] quad_ff;
  logic [27:0] phase_ff;
  logic [7:0]  rev_speed_ff;

  logic        wb_req;
  logic        prb_hit;
  logic        brk_low;
  logic        dir_change;
  logic [7:0]  rev_limit;
  logic [12:0] align_ms;
  logic [12:0] brake_ms;
  logic [15:0] gap_cyc;
  logic [28:0] phase_sum;
  logic        handoff;
  logic [2:0]  angle_steps;

  // Byte-lane merge for register writes
  function automatic logic [31:0] mss_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : mss_merge

  // Forward step of a 0..5 sector count
  function automatic logic [2:0] mss_wrap(input logic [3:0] s);
    logic [3:0] r;
    r = (s >= {1'b0, mss_pkg::SECTORS}) ? s - {1'b0, mss_pkg::SECTORS} : s;
    return r[2:0];
  endfunction : mss_wrap

  // Sector n energises into hi, out of lo; order VW WV UV VU WU UW (U=0, V=1, W=2)
  function automatic mss_pkg::mss_gate_t mss_pair(input logic [2:0] s);
    mss_pkg::mss_gate_t g;
    case (s)
      3'h0: g = '{hs: 3'b010, ls: 3'b100};
      3'h1: g = '{hs: 3'b100, ls: 3'b010};
      3'h2: g = '{hs: 3'b001, ls: 3'b010};
      3'h3: g = '{hs: 3'b010, ls: 3'b001};
      3'h4: g = '{hs: 3'b100, ls: 3'b001};
      3'h5: g = '{hs: 3'b001, ls: 3'b100};
      default: g = '{hs: 3'b000, ls: 3'b000};
    endcase
    return g;
  endfunction : mss_pair

  // ---------------- Wishbone slave ----------------
  assign wb_req = cyc_i & stb_i & ~ack_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg0_ff <= mss_pkg::CFG0_RST;
      cfg1_ff <= mss_pkg::CFG1_RST;
      cfg2_ff <= mss_pkg::CFG2_RST;
      ctrl_ff <= mss_pkg::CTRL_RST;
    end else if (wb_req && we_i) begin
      case (adr_i)
        mss_pkg::ADDR_CFG0: cfg0_ff <= mss_merge(cfg0_ff, dat_i, sel_i);
        mss_pkg::ADDR_CFG1: cfg1_ff <= mss_merge(cfg1_ff, dat_i, sel_i);
        mss_pkg::ADDR_CFG2: cfg2_ff <= mss_merge(cfg2_ff, dat_i, sel_i);
        mss_pkg::ADDR_CTRL: if (sel_i[0]) ctrl_ff <= dat_i[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= 32'h0000_0000;
    end else if (wb_req && !we_i) begin
      case (adr_i)
        mss_pkg::ADDR_CFG0:   rdata_ff <= cfg0_ff;
        mss_pkg::ADDR_CFG1:   rdata_ff <= cfg1_ff;
        mss_pkg::ADDR_CFG2:   rdata_ff <= cfg2_ff;
        mss_pkg::ADDR_CTRL:   rdata_ff <= {30'h0, ctrl_ff};
        mss_pkg::ADDR_STATUS: rdata_ff <= {23'h0, closed_loop_o, 1'b0, best_idx_ff, state_ff};
        default:              rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = rdata_ff;

  // ---------------- Pin synchronisers ----------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_sync_ff <= 3'h0;
      prb_sync_ff <= 2'h0;
      brk_sync_ff <= 2'h0;
    end else begin
      dir_sync_ff <= {dir_sync_ff[1:0], dir_i};
      prb_sync_ff <= {prb_sync_ff[0], cur_probe_i};
      brk_sync_ff <= {brk_sync_ff[0], cur_brake_low_i};
    end
  end

  assign prb_hit    = prb_sync_ff[1];
  assign brk_low    = brk_sync_ff[1];
  assign dir_change = dir_sync_ff[2] ^ dir_sync_ff[1];

  // Millisecond tick enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_ff <= 14'h0;
      tick_ff     <= 1'b0;
    end else if (tick_cnt_ff == 14'(TICK_CYCLES - 1)) begin
      tick_cnt_ff <= 14'h0;
      tick_ff     <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 14'h1;
      tick_ff     <= 1'b0;
    end
  end

  // ---------------- Frozen configuration ----------------
  // Snapshot taken while idle so a mid-start write cannot tear the attempt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_ff <= '0;
    end else if (state_ff == mss_pkg::MSS_IDLE) begin
      cfg_ff.brake_hold_time           <= cfg0_ff[mss_pkg::BRK_HOLD_LSB +: 3];
      cfg_ff.brake_exit_current        <= cfg0_ff[mss_pkg::BRK_CUR_LSB +: 2];
      cfg_ff.reverse_speed_limit       <= cfg0_ff[mss_pkg::REV_LIM_LSB +: 2];
      cfg_ff.align_duration            <= cfg0_ff[mss_pkg::ALIGN_LSB +: 3];
      cfg_ff.open_loop_current         <= cfg0_ff[mss_pkg::OL_CUR_LSB +: 2];
      cfg_ff.probe_current_threshold   <= cfg1_ff[mss_pkg::PRB_THR_LSB +: 4];
      cfg_ff.probe_release_select      <= cfg1_ff[mss_pkg::PRB_REL_BIT];
      cfg_ff.probe_pulse_interval      <= cfg1_ff[mss_pkg::PRB_GAP_LSB +: 2];
      cfg_ff.initial_drive_angle       <= cfg1_ff[mss_pkg::INIT_ANG_LSB +: 2];
      cfg_ff.closed_loop_handoff_speed <= cfg2_ff[mss_pkg::HANDOFF_LSB +: 5];
      cfg_ff.accel_linear_coef         <= cfg2_ff[mss_pkg::ACC_LIN_LSB +: 3];
      cfg_ff.accel_quadratic_coef      <= cfg2_ff[mss_pkg::ACC_QUAD_LSB +: 3];
      cfg_ff.reverse_drive_en          <= ctrl_ff[mss_pkg::REVDRV_EN_BIT];
    end
  end

  assign rev_limit   = mss_pkg::REV_LIM_BASE << cfg_ff.reverse_speed_limit;
  assign align_ms    = mss_pkg::ALIGN_BASE_MS << cfg_ff.align_duration;
  assign brake_ms    = mss_pkg::BRAKE_UNIT_MS << cfg_ff.brake_hold_time;
  assign gap_cyc     = 16'(mss_pkg::PROBE_GAP_CYC) << cfg_ff.probe_pulse_interval;
  assign handoff     = speed_ff[23:16] >= {3'h0, cfg_ff.closed_loop_handoff_speed};
  // Advance in 60 degree sectors: 0, 1, 2 and 2 sectors for the four codes
  assign angle_steps = {2'h0, cfg_ff.initial_drive_angle[1]} +
                       {2'h0, cfg_ff.initial_drive_angle[1] | cfg_ff.initial_drive_angle[0]};
  assign phase_sum   = {1'b0, phase_ff} + {5'h0, speed_ff};

  // ---------------- Sequencer ----------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      mss_pkg::MSS_IDLE: begin
        if (ctrl_ff[mss_pkg::RUN_BIT] && speed_valid_i) begin
          if (speed_value_i != 8'h00 && !speed_reverse_i) begin
            nxt_state = mss_pkg::MSS_CLOSED;
          end else if (speed_value_i != 8'h00) begin
            nxt_state = mss_pkg::MSS_COAST;
          end else if (cfg0_ff[mss_pkg::BRK_HOLD_LSB +: 3] != 3'h0) begin
            nxt_state = mss_pkg::MSS_BRAKE;
          end else if (cfg1_ff[mss_pkg::PRB_THR_LSB +: 4] != 4'h0) begin
            nxt_state = mss_pkg::MSS_PROBE;
          end else begin
            nxt_state = mss_pkg::MSS_ALIGN;
          end
        end
      end
      mss_pkg::MSS_COAST: begin
        if (speed_valid_i && speed_value_i < rev_limit) begin
          if (cfg_ff.reverse_drive_en) begin
            nxt_state = mss_pkg::MSS_REVDRV;
          end else if (cfg_ff.brake_hold_time != 3'h0) begin
            nxt_state = mss_pkg::MSS_BRAKE;
          end else if (cfg_ff.probe_current_threshold != 4'h0) begin
            nxt_state = mss_pkg::MSS_PROBE;
          end else begin
            nxt_state = mss_pkg::MSS_ALIGN;
          end
        end
      end
      mss_pkg::MSS_BRAKE: begin
        if (ms_cnt_ff >= brake_ms) begin
          nxt_state = (cfg_ff.probe_current_threshold != 4'h0) ? mss_pkg::MSS_PROBE
                                                               : mss_pkg::MSS_ALIGN;
        end
      end
      mss_pkg::MSS_PROBE: begin
        if (prb_hit || cyc_cnt_ff == mss_pkg::PROBE_MAX_CYC) begin
          nxt_state = mss_pkg::MSS_GAP;
        end
      end
      mss_pkg::MSS_GAP: begin
        if (cyc_cnt_ff >= gap_cyc) begin
          nxt_state = (probe_idx_ff == mss_pkg::SECTORS - 3'h1) ? mss_pkg::MSS_ACCEL : mss_pkg::MSS_PROBE;
        end
      end
      mss_pkg::MSS_ALIGN: begin
        if (ms_cnt_ff >= align_ms) begin
          nxt_state = mss_pkg::MSS_ACCEL;
        end
      end
      mss_pkg::MSS_REVDRV: begin
        if (speed_ff[23:16] >= rev_speed_ff) begin
          nxt_state = mss_pkg::MSS_ACCEL;
        end
      end
      mss_pkg::MSS_ACCEL: begin
        if (handoff) begin
          nxt_state = mss_pkg::MSS_CLOSED;
        end
      end
      mss_pkg::MSS_CLOSED: begin
        if (!ctrl_ff[mss_pkg::RUN_BIT]) begin
          nxt_state = mss_pkg::MSS_IDLE;
        end
      end
      default: nxt_state = mss_pkg::MSS_IDLE;
    endcase
    if (state_ff != mss_pkg::MSS_IDLE && state_ff != mss_pkg::MSS_CLOSED &&
        (dir_change || !ctrl_ff[mss_pkg::RUN_BIT])) begin
      nxt_state = mss_pkg::MSS_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= mss_pkg::MSS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Millisecond timer for align and brake; brake restarts it while current is high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ms_cnt_ff <= 13'h0;
    end else if (nxt_state != state_ff) begin
      ms_cnt_ff <= 13'h0;
    end else if (state_ff == mss_pkg::MSS_BRAKE && !brk_low) begin
      ms_cnt_ff <= 13'h0;
    end else if (tick_ff && ms_cnt_ff != 13'h1fff) begin
      ms_cnt_ff <= ms_cnt_ff + 13'h1;
    end
  end

  // Probe timing: count from voltage on, keep the shortest
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cyc_cnt_ff <= 16'h0;
    end else if (nxt_state != state_ff) begin
      cyc_cnt_ff <= 16'h0;
    end else if (cyc_cnt_ff != mss_pkg::PROBE_MAX_CYC) begin
      cyc_cnt_ff <= cyc_cnt_ff + 16'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      probe_idx_ff <= 3'h0;
      best_time_ff <= mss_pkg::PROBE_MAX_CYC;
      best_idx_ff  <= 3'h0;
    end else if (state_ff == mss_pkg::MSS_IDLE) begin
      probe_idx_ff <= 3'h0;
      best_time_ff <= mss_pkg::PROBE_MAX_CYC;
      best_idx_ff  <= 3'h0;
    end else if (state_ff == mss_pkg::MSS_PROBE && nxt_state == mss_pkg::MSS_GAP) begin
      if (cyc_cnt_ff < best_time_ff) begin
        best_time_ff <= cyc_cnt_ff;
        best_idx_ff  <= probe_idx_ff;
      end
    end else if (state_ff == mss_pkg::MSS_GAP && nxt_state == mss_pkg::MSS_PROBE) begin
      probe_idx_ff <= probe_idx_ff + 3'h1;
    end
  end

  // Open-loop ramp: speed grows by the linear step plus a growing quadratic term
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      speed_ff     <= 24'h0;
      quad_ff      <= 24'h0;
      rev_speed_ff <= 8'h0;
    end else if (state_ff == mss_pkg::MSS_IDLE) begin
      speed_ff     <= 24'h0;
      quad_ff      <= 24'h0;
      rev_speed_ff <= speed_value_i;
    end else if (state_ff == mss_pkg::MSS_COAST) begin
      rev_speed_ff <= speed_value_i;
    end else if (tick_ff && (state_ff == mss_pkg::MSS_ACCEL || state_ff == mss_pkg::MSS_REVDRV)) begin
      quad_ff  <= quad_ff + (mss_pkg::ACC_QUAD_BASE << cfg_ff.accel_quadratic_coef);
      speed_ff <= speed_ff + (mss_pkg::ACC_LIN_BASE << cfg_ff.accel_linear_coef) + quad_ff;
    end
  end

  // Commutation sector: set by align or probing, stepped blindly in open loop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sector_ff <= mss_pkg::ALIGN_SECTOR;
      phase_ff  <= 28'h0;
    end else if (state_ff == mss_pkg::MSS_IDLE || state_ff == mss_pkg::MSS_ALIGN) begin
      sector_ff <= mss_pkg::ALIGN_SECTOR;
      phase_ff  <= 28'h0;
    end else if (state_ff == mss_pkg::MSS_GAP && nxt_state == mss_pkg::MSS_ACCEL) begin
      sector_ff <= mss_wrap({1'b0, best_idx_ff} + {1'b0, angle_steps});
    end else if (state_ff == mss_pkg::MSS_ACCEL || state_ff == mss_pkg::MSS_REVDRV) begin
      phase_ff <= phase_sum[27:0];
      if (phase_sum[28]) begin
        sector_ff <= mss_wrap({1'b0, sector_ff} + 4'h1);
      end
    end
  end

  // ---------------- Power switch drive ----------------
  always_comb begin
    nxt_gate = '{hs: 3'b000, ls: 3'b000};
    case (state_ff)
      mss_pkg::MSS_BRAKE: nxt_gate = '{hs: 3'b000, ls: 3'b111};
      mss_pkg::MSS_ALIGN: nxt_gate = mss_pair(mss_pkg::ALIGN_SECTOR);
      mss_pkg::MSS_PROBE: nxt_gate = mss_pair(probe_idx_ff);
      mss_pkg::MSS_GAP: begin
        if (!cfg_ff.probe_release_select) begin
          nxt_gate    = mss_pair(probe_idx_ff);
          nxt_gate.hs = 3'b000;
        end else begin
          nxt_gate = '{hs: 3'b000, ls: 3'b000};
        end
      end
      mss_pkg::MSS_ACCEL,
      mss_pkg::MSS_REVDRV: nxt_gate = mss_pair(sector_ff);
      default: nxt_gate = '{hs: 3'b000, ls: 3'b000};
    endcase
    if (nxt_state == mss_pkg::MSS_IDLE) begin
      nxt_gate = '{hs: 3'b000, ls: 3'b000};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hs_on_o          <= 3'h0;
      ls_on_o          <= 3'h0;
      drive_level_o    <= 2'h0;
      closed_loop_o    <= 1'b0;
      handoff_sector_o <= 3'h0;
    end else begin
      hs_on_o       <= nxt_gate.hs;
      ls_on_o       <= nxt_gate.ls;
      // Follows the state like the switch drive, so it rises on the same edge that releases the switches
      closed_loop_o <= (state_ff == mss_pkg::MSS_CLOSED);
      handoff_sector_o <= sector_ff;
      if ((state_ff == mss_pkg::MSS_ALIGN || state_ff == mss_pkg::MSS_ACCEL ||
           state_ff == mss_pkg::MSS_REVDRV) && nxt_state != mss_pkg::MSS_IDLE) begin
        drive_level_o <= cfg_ff.open_loop_current;
      end else begin
        drive_level_o <= 2'h0;
      end
    end
  end

  assign probe_threshold_o = cfg_ff.probe_current_threshold;
  assign brake_threshold_o = cfg_ff.brake_exit_current;

endmodule : mss_sequencer

// File: test/mss_checker.sv
// Concurrent checks on the sequencer's bus handshake and power switch outputs.
// Bound to every mss_sequencer instance; sees only its ports.
`timescale 1ns/10ps
module mss_checker (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o,
  input wire logic       dir_i,
  input wire logic [2:0] hs_on_o,
  input wire logic [2:0] ls_on_o,
  input wire logic [1:0] drive_level_o,
  input wire logic [3:0] probe_threshold_o,
  input wire logic       closed_loop_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_quiet;
    hs_on_o == 3'h0 && ls_on_o == 3'h0 && drive_level_o == 2'h0;
  endsequence
  a_ack_after_req: assert property (s_req |=> ack_o)
    else $error("no ack one cycle after a request");
  a_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_brake_no_high: assert property (ls_on_o == 3'h7 |-> hs_on_o == 3'h0)
    else $error("high side on with all low sides on");
  a_one_high_side: assert property ($countones(hs_on_o) <= 1)
    else $error("more than one high side on");
  a_no_shoot_thru: assert property ((hs_on_o & ls_on_o) == 3'h0)
    else $error("both switches of one phase on");
  a_high_has_low: assert property (hs_on_o != 3'h0 |-> ls_on_o != 3'h0)
    else $error("high side on without a return path");
  a_closed_quiet: assert property (closed_loop_o |-> s_quiet)
    else $error("switches driven after handoff");
  a_dir_abort: assert property (($changed(dir_i) && !closed_loop_o) |-> ##[1:6] s_quiet)
    else $error("drive not stopped after direction change");
  a_cfg_frozen: assert property ((hs_on_o != 3'h0 && $past(hs_on_o) != 3'h0) |-> $stable(probe_threshold_o))
    else $error("probe threshold moved during a start");
endmodule : mss_checker

bind mss_sequencer mss_checker i_mss_checker (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .dir_i, .hs_on_o,
  .ls_on_o, .drive_level_o, .probe_threshold_o, .closed_loop_o);

// File: test/mss_motor_model.sv
// Behavioural windings: current rises sooner on one chosen pair, brake current decays.
// Fed by the sequencer's switch outputs; the bench picks the fast pair.
`timescale 1ns/10ps
module mss_motor_model (
  input  wire logic       clk_i,
  input  wire logic [2:0] hs_i,
  input  wire logic [2:0] ls_i,
  input  wire logic [5:0] fast_i,
  output logic            cur_probe_o,
  output logic            cur_brake_low_o
);
  logic [7:0] pcnt_ff;
  logic [7:0] bcnt_ff;
  // Saturating counts so a long drive never wraps back below threshold
  always_ff @(posedge clk_i) pcnt_ff <= (hs_i == 3'h0) ? 8'h00 : pcnt_ff + {7'h00, pcnt_ff != 8'hff};
  always_ff @(posedge clk_i) bcnt_ff <= (ls_i != 3'h7) ? 8'h00 : bcnt_ff + {7'h00, bcnt_ff != 8'hff};
  assign cur_probe_o     = pcnt_ff >= (({hs_i, ls_i} == fast_i) ? 8'h06 : 8'h10);
  assign cur_brake_low_o = bcnt_ff >= 8'h28;
endmodule : mss_motor_model

// File: test/mss_sequencer_test.sv
// Self-checking bench: register access, then align, brake, probe and reverse starts
// against the winding model. Assumes TICK_CYCLES of 10 cycles per ms.
`timescale 1ns/10ps
module mss_sequencer_test;
  logic        clk_i, rst_i, cyc, stb, we, ack, dir, spd_v, spd_r, cprb, cbrk, closed;
  logic [7:0]  adr, spd;
  logic [31:0] dat, dout, rdat, seed;
  logic [2:0]  hs, ls, sect;
  logic [1:0]  lvl, bthr;
  logic [3:0]  pthr;
  logic [5:0]  fast;
  int          bad_count, total_checks;
  logic [5:0]  ord [6] = '{6'h14, 6'h22, 6'h0a, 6'h11, 6'h21, 6'h0c};
  mss_sequencer #(.TICK_CYCLES(10)) i_mss_sequencer (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(dout), .ack_o(ack), .dir_i(dir), .cur_probe_i(cprb),
    .cur_brake_low_i(cbrk), .speed_valid_i(spd_v), .speed_reverse_i(spd_r), .speed_value_i(spd),
    .hs_on_o(hs), .ls_on_o(ls), .drive_level_o(lvl), .probe_threshold_o(pthr), .brake_threshold_o(bthr),
    .handoff_sector_o(sect), .closed_loop_o(closed));
  mss_motor_model i_mss_motor_model (.clk_i, .hs_i(hs), .ls_i(ls), .fast_i(fast), .cur_probe_o(cprb),
    .cur_brake_low_o(cbrk));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [2:0] exp_sect(input logic [2:0] k, input logic [1:0] a);
    logic [2:0] v;
    v = k + ((a == 2'h0) ? 3'h0 : (a == 2'h1) ? 3'h1 : 3'h2);
    return (v >= 3'h6) ? v - 3'h6 : v;
  endfunction : exp_sect
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Called on a rising edge; returns on a rising edge with the bus idle again
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    while (ack !== 1'b1) begin
      @(negedge clk_i);
    end
    @(posedge clk_i);
    rdat = dout;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic setup(input logic [31:0] c0, input logic [31:0] c1, input logic [1:0] ctl);
    wb(1'b1, mss_pkg::ADDR_CFG0, c0);
    wb(1'b1, mss_pkg::ADDR_CFG1, c1);
    wb(1'b1, mss_pkg::ADDR_CFG2, xs() & 32'h0000771f);
    wb(1'b1, mss_pkg::ADDR_CTRL, {30'h0, ctl});
  endtask : setup
  task automatic halt();
    wb(1'b1, mss_pkg::ADDR_CTRL, 32'h0);
    repeat (4) @(posedge clk_i);
  endtask : halt
  task automatic align_run(input logic [2:0] hold);
    logic [1:0] oc;
    int n, bc, seen;
    oc = 2'(xs());
    n = 0; bc = 0; seen = 0;
    setup((32'(oc) << 20) | 32'(hold), 32'h0, 2'h1);
    while (!(hs == 3'h2 && ls == 3'h4) && n < 3000) begin
      @(negedge clk_i);
      n++;
      if (ls == 3'h7) bc++;
    end
    // Model decay of 40 cycles plus sync, then 20 ms of 10 cycles, within one tick of phase
    if (hold == 3'h0) chk("brake_cycles", 0, bc);
    else chk("brake_hold", 1, bc >= 235 && bc <= 255);
    chk("align_reached", 1, n < 3000);
    repeat (300) @(negedge clk_i);
    chk("align_pair", 6'h14, {hs, ls});
    chk("align_level", oc, lvl);
    @(posedge clk_i) dir <= ~dir;
    repeat (8) begin
      @(negedge clk_i);
      if ({hs, ls, lvl} === 8'h00) seen = 1;
    end
    chk("dir_abort", 1, seen);
    @(posedge clk_i);
    halt();
  endtask : align_run
  task automatic probe_run(input logic rel);
    logic [2:0] k, ph;
    logic [1:0] a;
    logic [3:0] t;
    logic [5:0] last;
    int n, m;
    k = 3'(xs() % 6); a = 2'(xs()); t = 4'(xs()) | 4'h1;
    last = 6'h00; ph = 3'h0; n = 0; m = 0;
    fast <= ord[k];
    // Shortest gap is enough here: the model's current is gone as soon as drive stops
    setup(32'h00100000, (32'(a) << 12) | (32'(rel) << 4) | 32'(t), 2'h1);
    while (lvl == 2'h0 && m < 20000) begin
      @(negedge clk_i);
      m++;
      if (hs != 3'h0 && {hs, ls} != last && n < 6) begin
        chk("probe_pair", ord[n], {hs, ls});
        last = {hs, ls};
        n++;
      end
      if (ph != 3'h0 && hs == 3'h0) chk("release_low", rel ? 3'h0 : last[2:0], ls);
      ph = hs;
    end
    chk("probe_done", 1, m < 20000);
    chk("probe_count", 6, n);
    chk("start_sector", exp_sect(k, a), sect);
    chk("probe_thr", t, pthr);
    @(posedge clk_i);
    wb(1'b0, mss_pkg::ADDR_STATUS, 32'h0);
    chk("best_index", k, rdat[6:4]);
    halt();
  endtask : probe_run
  task automatic rev_run();
    int n;
    n = 0;
    spd_r <= 1'b1; spd <= 8'h28;
    setup(32'h00100000, 32'h0, 2'h3);
    repeat (100) @(negedge clk_i);
    chk("coast_out", 0, {hs, ls, lvl});
    @(posedge clk_i) spd <= 8'h05;
    while (lvl == 2'h0 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    chk("revdrv_level", 1, lvl);
    @(posedge clk_i);
    halt();
  endtask : rev_run
  task automatic report_and_stop();
    if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (80000) @(posedge clk_i);
    bad_count++;
    report_and_stop();
  end
  initial begin
    seed = 32'h00015b4d; bad_count = 0; total_checks = 0; rst_i = 1'b1;
    cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; dat = 32'h0; dir = 1'b0;
    spd_v = 1'b0; spd_r = 1'b0; spd = 8'h00; fast = 6'h00;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped_read", 0, rdat);
    wb(1'b0, mss_pkg::ADDR_CFG0, 32'h0);
    chk("cfg0_reset", mss_pkg::CFG0_RST, rdat);
    spd_v <= 1'b1;
    align_run(3'h0);
    align_run(3'h1);
    probe_run(1'b0);
    probe_run(1'b1);
    rev_run();
    report_and_stop();
  end
endmodule : mss_sequencer_test
